/* rtl/fcr_pkg.sv */
// Shared constants for the floppy configure / relative seek / perpendicular block
package fcr_pkg;
	// ----------------------------------------------------------------
	// Register port geometry and offsets
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] A_CONFIG = 4'h0;
	localparam logic [3:0] A_THRESH = 4'h1;
	localparam logic [3:0] A_PRECOMP = 4'h2;
	localparam logic [3:0] A_VERSION = 4'h3;
	localparam logic [3:0] A_PERP = 4'h4;
	localparam logic [3:0] A_SPECIFY = 4'h5;
	localparam logic [3:0] A_RCOUNT = 4'h6;
	localparam logic [3:0] A_COMMAND = 4'h7;
	localparam logic [3:0] A_STATUS = 4'h8;
	localparam logic [3:0] A_CYL = 4'h9;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_ISEEK = 0;
	localparam int CFG_FIFODIS = 1;
	localparam int CFG_POLLDIS = 2;
	localparam int CFG_LOCK = 3;
	localparam int PERP_GAP = 0;
	localparam int PERP_WG = 1;
	localparam int PERP_DRV = 2;
	localparam int PERP_OW = 7;
	localparam int CMD_DIR = 0;
	localparam int CMD_RSEEK = 1;
	localparam int CMD_RECAL = 2;
	localparam int ST_BUSY = 0;
	localparam int ST_EC = 4;
	localparam int ST_SE = 5;
	localparam int ST_POLL = 6;
	// ----------------------------------------------------------------
	// Reset values and fixed figures
	// ----------------------------------------------------------------
	localparam logic [7:0] CFG_RST = 8'h02;
	localparam logic [3:0] THRESH_RST = 4'h0;
	localparam logic [7:0] PRECOMP_RST = 8'h00;
	localparam logic [3:0] SRT_RST = 4'h0;
	localparam logic [7:0] RECAL_MAX_STEPS = 8'h50;
	localparam logic [5:0] GAP2_CONV = 6'h16;
	localparam logic [5:0] GAP2_PERP_1M = 6'h29;
	localparam logic [5:0] VCO_CONV = 6'h18;
	localparam logic [5:0] VCO_PERP_1M = 6'h2B;
	localparam logic [5:0] WG_BYTES_1M = 6'h26;
	localparam logic [5:0] WG_BYTES_500K = 6'h13;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int STEP_UNIT_US = 1000;
	localparam int STEP_UNIT_CYC_DFLT = STEP_UNIT_US * CLK_MHZ;
	localparam int STEP_PULSE_NS = 1000;
	localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
endpackage : fcr_pkg

/* rtl/fcr_step_if.sv */
// Link between the seek controller and the step pulse generator
`timescale 1ns/10ps
interface fcr_step_if;
	logic start;
	logic abort;
	logic dir;
	logic [7:0] count;
	logic [3:0] rate;
	logic step;
	logic busy;
	logic more;
	modport ctrl(output start, abort, dir, count, rate,
		input step, busy, more);
	modport unit(input start, abort, dir, count, rate,
		output step, busy, more);
endinterface : fcr_step_if

/* rtl/fcr_stepper.sv */
// Step pulse generator with programmable step spacing
`timescale 1ns/10ps
module fcr_stepper #(
	parameter int unsigned UNIT = fcr_pkg::STEP_UNIT_CYC_DFLT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	fcr_step_if.unit sif
);
	import fcr_pkg::*;
	typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_WAIT} fcr_stp_state_t;
	fcr_stp_state_t st_q;
	logic [7:0] rem_q;
	logic [19:0] cnt_q;
	logic [3:0] rate_q;
	logic step_q;
	logic [19:0] interval;

	// ----------------------------------------------------------------
	// Step spacing
	// ----------------------------------------------------------------
	// Rate is latched at start so a mid-seek rewrite cannot shorten a gap
	assign interval = 20'((5'd16 - {1'b0, rate_q}) * UNIT);
	assign sif.step = step_q;
	assign sif.busy = (st_q != ST_IDLE);
	assign sif.more = (rem_q != 8'h00);

	// Pulse then wait, once per remaining step
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= ST_IDLE;
			rem_q <= 8'h00;
			cnt_q <= 20'h00000;
			rate_q <= SRT_RST;
			step_q <= 1'b0;
		end else if (ce) begin
			if (sif.abort) begin
				st_q <= ST_IDLE;
				rem_q <= 8'h00;
				step_q <= 1'b0;
			end else begin
				case (st_q)
					ST_IDLE: begin
						if (sif.start && sif.count != 8'h00) begin
							rem_q <= sif.count - 8'h01;
							rate_q <= sif.rate;
							cnt_q <= 20'(STEP_PULSE_CYC - 1);
							step_q <= 1'b1;
							st_q <= ST_PULSE;
						end
					end
					ST_PULSE: begin
						if (cnt_q == 20'h00000) begin
							step_q <= 1'b0;
							cnt_q <= interval - 20'(STEP_PULSE_CYC + 1);
							st_q <= ST_WAIT;
						end else begin
							cnt_q <= cnt_q - 20'h00001;
						end
					end
					ST_WAIT: begin
						if (cnt_q != 20'h00000) begin
							cnt_q <= cnt_q - 20'h00001;
						end else if (rem_q == 8'h00) begin
							st_q <= ST_IDLE;
						end else begin
							rem_q <= rem_q - 8'h01;
							cnt_q <= 20'(STEP_PULSE_CYC - 1);
							step_q <= 1'b1;
							st_q <= ST_PULSE;
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Cycles since the previous step rise, for the spacing check
	logic [19:0] gap_q;
	logic seen_q;
	always_ff @(posedge clk) begin
		if (rst || st_q == ST_IDLE) begin
			gap_q <= 20'h00000;
			seen_q <= 1'b0;
		end else if (ce && step_q && st_q == ST_PULSE
			&& cnt_q == 20'(STEP_PULSE_CYC - 1)) begin
			gap_q <= 20'h00000;
			seen_q <= 1'b1;
		end else if (ce && gap_q != 20'hFFFFF) begin
			gap_q <= gap_q + 20'h00001;
		end
	end

	a_step_spacing: assert property (@(posedge clk) disable iff (rst)
		($rose(step_q) && seen_q) |-> (gap_q + 20'h00001 >= interval))
		else $error("step pulses closer than the step rate time");
endmodule : fcr_stepper

/* rtl/fcr_top.sv */
// Configure, version, relative seek and perpendicular mode control
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module fcr_top #(
	parameter int unsigned STEP_UNIT_CYC = fcr_pkg::STEP_UNIT_CYC_DFLT,
	parameter logic [7:0] VERSION_BYTE = 8'h5A // Arbitrary value
) (
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic SOFT_RESET,
	input wire logic [fcr_pkg::ADDR_W-1:0] ADDR,
	input wire logic [fcr_pkg::DATA_W-1:0] WDATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output logic [fcr_pkg::DATA_W-1:0] RDATA,
	input wire logic TRK0_N,
	input wire logic HEAD_LOADED,
	input wire logic RW_CMD_START,
	input wire logic RATE_1M,
	input wire logic [1:0] DRIVE_SEL,
	input wire logic GAP2_START,
	input wire logic BYTE_TICK,
	input wire logic READ_ACTIVE,
	input wire logic WRITE_ACTIVE,
	output logic STEP,
	output logic DIR,
	output logic SEEK_BUSY,
	output logic POLL_INT,
	output logic IMPLIED_SEEK_REQ,
	output logic FIFO_BYPASS,
	output logic [3:0] FIFO_THRESH,
	output logic [7:0] PRECOMP_TRACK,
	output logic PRECOMP_ZERO,
	output logic PERP_DRIVE,
	output logic [5:0] GAP2_LEN,
	output logic VCO_EN,
	output logic WRITE_GATE
);
	import fcr_pkg::*;
	typedef enum logic [1:0] {SK_IDLE, SK_RSEEK, SK_RECAL} fcr_seek_state_t;

	fcr_step_if sif();
	fcr_seek_state_t sk_q;
	logic iseek_q, fifodis_q, polldis_q, lock_q;
	logic [3:0] thr_q, srt_q, thr_out_q, drv_q;
	logic [7:0] precomp_q, rcnt_q, cyl_q, count_q, rdata_q;
	logic gap_q, wg_q, dir_q, start_q, abort_q, ec_q, se_q;
	logic poll_q, arm_q, step_prev_q, iseek_req_q, busy_q;
	logic trk0_m_q, trk0_s_q, trk0;
	logic perp_drv_q, pzero_q, vco_q, write_gate_select_q, win_q;
	logic [5:0] gap2_q, byte_q;
	logic step_edge, cmd_wr, stat_rd, perp_1m, perp_500, drive_perp;
	logic [5:0] vco_thr, wg_thr;

	// ----------------------------------------------------------------
	// Step generator
	// ----------------------------------------------------------------
	fcr_stepper #(.UNIT(STEP_UNIT_CYC)) u_step (
		.clk(SYS_CLK),
		.rst(RESET),
		.ce(CE),
		.sif(sif.unit)
	);
	assign sif.start = start_q;
	assign sif.abort = abort_q;
	assign sif.dir = dir_q;
	assign sif.count = count_q;
	assign sif.rate = srt_q;

	// Output ports, each a flop
	assign STEP = sif.step;
	assign DIR = dir_q;
	assign SEEK_BUSY = busy_q;
	assign RDATA = rdata_q;
	assign POLL_INT = poll_q;
	assign IMPLIED_SEEK_REQ = iseek_req_q;
	assign FIFO_BYPASS = fifodis_q;
	assign FIFO_THRESH = thr_out_q;
	assign PRECOMP_TRACK = precomp_q;
	assign PRECOMP_ZERO = pzero_q;
	assign PERP_DRIVE = perp_drv_q;
	assign GAP2_LEN = gap2_q;
	assign VCO_EN = vco_q;
	assign WRITE_GATE = write_gate_select_q;

	assign step_edge = sif.step && !step_prev_q;
	assign cmd_wr = WR_STB && ADDR == A_COMMAND;
	assign stat_rd = RD_STB && ADDR == A_STATUS;
	assign trk0 = !trk0_s_q;

	// Track-zero pin is asynchronous to the controller clock
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			trk0_m_q <= 1'b1;
			trk0_s_q <= 1'b1;
		end else if (CE) begin
			trk0_m_q <= TRK0_N;
			trk0_s_q <= trk0_m_q;
		end
	end

	// ----------------------------------------------------------------
	// Configure parameters
	// ----------------------------------------------------------------
	// Soft reset restores FIFO bypass, threshold and precomp unless locked; hard reset restores all
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			iseek_q <= CFG_RST[CFG_ISEEK];
			fifodis_q <= CFG_RST[CFG_FIFODIS];
			polldis_q <= CFG_RST[CFG_POLLDIS];
			lock_q <= CFG_RST[CFG_LOCK];
			thr_q <= THRESH_RST;
			precomp_q <= PRECOMP_RST;
			srt_q <= SRT_RST;
			rcnt_q <= 8'h00;
		end else if (CE) begin
			if (SOFT_RESET) begin
				if (!lock_q) begin
					fifodis_q <= CFG_RST[CFG_FIFODIS];
					thr_q <= THRESH_RST;
					precomp_q <= PRECOMP_RST;
				end
			end else if (WR_STB) begin
				case (ADDR)
					A_CONFIG: begin
						iseek_q <= WDATA[CFG_ISEEK];
						fifodis_q <= WDATA[CFG_FIFODIS];
						polldis_q <= WDATA[CFG_POLLDIS];
						lock_q <= WDATA[CFG_LOCK];
					end
					A_THRESH: thr_q <= WDATA[3:0];
					A_PRECOMP: precomp_q <= WDATA;
					A_SPECIFY: srt_q <= WDATA[3:0];
					A_RCOUNT: rcnt_q <= WDATA;
					default: ;
				endcase
			end
		end
	end

	// Perpendicular mode bits; soft reset spares the drive bits
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			gap_q <= 1'b0;
			wg_q <= 1'b0;
			drv_q <= 4'h0;
		end else if (CE) begin
			if (SOFT_RESET) begin
				gap_q <= 1'b0;
				wg_q <= 1'b0;
			end else if (WR_STB && ADDR == A_PERP) begin
				gap_q <= WDATA[PERP_GAP];
				wg_q <= WDATA[PERP_WG];
				if (WDATA[PERP_OW]) begin
					drv_q <= WDATA[PERP_DRV+:4];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Relative seek and recalibrate
	// ----------------------------------------------------------------
	// Status clears on read first, so a same-cycle completion still sets
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			sk_q <= SK_IDLE;
			start_q <= 1'b0;
			abort_q <= 1'b0;
			dir_q <= 1'b0;
			count_q <= 8'h00;
			cyl_q <= 8'h00;
			ec_q <= 1'b0;
			se_q <= 1'b0;
			busy_q <= 1'b0;
		end else if (CE) begin
			// Busy pin is a flop, so it trails the state by one cycle
			busy_q <= (sk_q != SK_IDLE);
			start_q <= 1'b0;
			abort_q <= 1'b0;
			if (stat_rd) begin
				ec_q <= 1'b0;
				se_q <= 1'b0;
			end
			if (WR_STB && ADDR == A_CYL) begin
				cyl_q <= WDATA;
			end
			if (step_edge && sk_q == SK_RSEEK) begin
				cyl_q <= dir_q ? cyl_q + 8'h01 : cyl_q - 8'h01;
			end
			case (sk_q)
				SK_IDLE: begin
					// A command is ignored unless the stepper is idle
					if (cmd_wr && !SOFT_RESET && !sif.busy && !abort_q) begin
						if (WDATA[CMD_RECAL]) begin
							cyl_q <= 8'h00;
							dir_q <= 1'b0;
							if (trk0) begin
								se_q <= 1'b1;
							end else begin
								count_q <= RECAL_MAX_STEPS;
								start_q <= 1'b1;
								sk_q <= SK_RECAL;
							end
						end else if (WDATA[CMD_RSEEK]) begin
							dir_q <= WDATA[CMD_DIR];
							count_q <= rcnt_q;
							if (rcnt_q == 8'h00) begin
								se_q <= 1'b1;
							end else if (!WDATA[CMD_DIR] && trk0) begin
								ec_q <= 1'b1;
								se_q <= 1'b1;
							end else begin
								start_q <= 1'b1;
								sk_q <= SK_RSEEK;
							end
						end
					end
				end
				SK_RSEEK: begin
					if (trk0 && !dir_q && sif.more && !sif.step) begin
						abort_q <= 1'b1;
						ec_q <= 1'b1;
						se_q <= 1'b1;
						sk_q <= SK_IDLE;
					end else if (!start_q && !sif.busy) begin
						se_q <= 1'b1;
						sk_q <= SK_IDLE;
					end
				end
				SK_RECAL: begin
					if (trk0) begin
						abort_q <= 1'b1;
						se_q <= 1'b1;
						sk_q <= SK_IDLE;
					end else if (!start_q && !sif.busy) begin
						ec_q <= 1'b1;
						se_q <= 1'b1;
						sk_q <= SK_IDLE;
					end
				end
				default: sk_q <= SK_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Polling, implied seek, register reads
	// ----------------------------------------------------------------
	// One poll event armed per reset, held off while the head is loaded
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			arm_q <= 1'b1;
			poll_q <= 1'b0;
			step_prev_q <= 1'b0;
			iseek_req_q <= 1'b0;
		end else if (CE) begin
			step_prev_q <= sif.step;
			iseek_req_q <= RW_CMD_START && iseek_q;
			if (stat_rd) begin
				poll_q <= 1'b0;
			end
			if (SOFT_RESET) begin
				arm_q <= 1'b1;
			end else if (arm_q && polldis_q) begin
				arm_q <= 1'b0;
			end else if (arm_q && !HEAD_LOADED) begin
				poll_q <= 1'b1;
				arm_q <= 1'b0;
			end
		end
	end

	// Read data stands for one cycle only; unmapped reads give zero
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			rdata_q <= 8'h00;
		end else if (CE) begin
			rdata_q <= 8'h00;
			if (RD_STB) begin
				case (ADDR)
					A_CONFIG: rdata_q <= {4'h0, lock_q, polldis_q,
						fifodis_q, iseek_q};
					A_THRESH: rdata_q <= {4'h0, thr_q};
					A_PRECOMP: rdata_q <= precomp_q;
					A_VERSION: rdata_q <= VERSION_BYTE;
					A_PERP: rdata_q <= {2'b00, drv_q, wg_q, gap_q};
					A_SPECIFY: rdata_q <= {4'h0, srt_q};
					A_RCOUNT: rdata_q <= rcnt_q;
					A_STATUS: rdata_q <= {1'b0, poll_q, se_q, ec_q,
						3'b000, sk_q != SK_IDLE};
					A_CYL: rdata_q <= cyl_q;
					default: rdata_q <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Recording mode and gap timing
	// ----------------------------------------------------------------
	// Gap/WG modes do not follow the data rate, software keeps them in step; drive bit modes follow RATE_1M
	always_comb begin
		drive_perp = !gap_q && !wg_q && drv_q[DRIVE_SEL];
		perp_1m = (gap_q && wg_q) || (drive_perp && RATE_1M);
		perp_500 = (gap_q && !wg_q) || (drive_perp && !RATE_1M);
		vco_thr = perp_1m ? VCO_PERP_1M : VCO_CONV;
		if (perp_1m) begin
			wg_thr = GAP2_PERP_1M - WG_BYTES_1M;
		end else if (perp_500) begin
			wg_thr = GAP2_CONV - WG_BYTES_500K;
		end else begin
			wg_thr = GAP2_CONV;
		end
	end

	// Mode outputs and the FIFO threshold seen by the datapath
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			gap2_q <= GAP2_CONV;
			perp_drv_q <= 1'b0;
			pzero_q <= 1'b0;
			thr_out_q <= THRESH_RST;
		end else if (CE) begin
			gap2_q <= perp_1m ? GAP2_PERP_1M : GAP2_CONV;
			perp_drv_q <= perp_1m || perp_500;
			pzero_q <= drive_perp;
			thr_out_q <= fifodis_q ? THRESH_RST : thr_q;
		end
	end

	// Byte count from the start of Gap2 drives VCO and write gate
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			byte_q <= 6'h00;
			win_q <= 1'b0;
			vco_q <= 1'b0;
			write_gate_select_q <= 1'b0;
		end else if (CE) begin
			if (GAP2_START) begin
				byte_q <= 6'h00;
				win_q <= 1'b1;
			end else if (!READ_ACTIVE && !WRITE_ACTIVE) begin
				win_q <= 1'b0;
			end else if (BYTE_TICK && byte_q != 6'h3F) begin
				byte_q <= byte_q + 6'h01;
			end
			vco_q <= READ_ACTIVE && win_q && byte_q >= vco_thr;
			write_gate_select_q <= WRITE_ACTIVE && win_q && byte_q >= wg_thr;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);

	// Helpers: recal steps taken, poll events since the last reset
	logic [7:0] rc_steps_q;
	logic [1:0] polls_q;
	always_ff @(posedge SYS_CLK) begin
		if (RESET || SOFT_RESET) begin
			polls_q <= 2'b00;
		end else if (CE && arm_q && !polldis_q && !HEAD_LOADED) begin
			polls_q <= polls_q + 2'b01;
		end
	end
	always_ff @(posedge SYS_CLK) begin
		if (RESET || sk_q != SK_RECAL) begin
			rc_steps_q <= 8'h00;
		end else if (CE && step_edge) begin
			rc_steps_q <= rc_steps_q + 8'h01;
		end
	end

	a_fifo_default: assert property ($past(RESET) |->
		FIFO_BYPASS && FIFO_THRESH == THRESH_RST && PRECOMP_TRACK == 8'h00)
		else $error("configure defaults wrong after reset");
	a_thresh_bypass: assert property (FIFO_BYPASS && $past(FIFO_BYPASS)
		|-> FIFO_THRESH == THRESH_RST)
		else $error("threshold not one byte while bypassed");
	a_version_read: assert property (CE && RD_STB && ADDR == A_VERSION
		|=> RDATA == VERSION_BYTE)
		else $error("version byte wrong");
	a_cyl_step: assert property (CE && step_edge && sk_q == SK_RSEEK
		|=> cyl_q == ($past(dir_q) ? $past(cyl_q) + 8'h01
		: $past(cyl_q) - 8'h01))
		else $error("cylinder not updated by one per step");
	a_recal_limit: assert property (rc_steps_q <= RECAL_MAX_STEPS
		&& !(sk_q == SK_RECAL && STEP && DIR))
		else $error("recalibrate stepped wrongly");
	a_poll_once: assert property (polls_q <= 2'b01)
		else $error("more than one poll event after reset");
	a_perp_reset: assert property ($past(RESET) |-> !gap_q && !wg_q
		&& GAP2_LEN == GAP2_CONV ##1 !PERP_DRIVE || drv_q != 4'h0)
		else $error("perpendicular mode not cleared by reset");
	a_soft_keep: assert property (CE && SOFT_RESET |=> !gap_q && !wg_q
		&& drv_q == $past(drv_q))
		else $error("soft reset disturbed drive bits");
	a_lock_keep: assert property (CE && SOFT_RESET && lock_q |=>
		thr_q == $past(thr_q) && precomp_q == $past(precomp_q))
		else $error("locked settings lost on soft reset");
	a_gap2_len: assert property (CE |=> GAP2_LEN ==
		($past(perp_1m) ? GAP2_PERP_1M : GAP2_CONV))
		else $error("gap2 length does not match mode");
	a_vco_timing: assert property (CE && READ_ACTIVE && win_q
		&& byte_q < vco_thr |=> !VCO_EN)
		else $error("VCO enabled too early");
	a_ec_outward: assert property (CE && sk_q == SK_RSEEK
		&& trk0 && !dir_q && sif.more && !sif.step
		|=> ec_q && sk_q == SK_IDLE)
		else $error("outward step past track zero not flagged");

	c_rseek_done: cover property (sk_q == SK_RSEEK ##1 sk_q == SK_IDLE);
	c_recal_err: cover property (sk_q == SK_RECAL ##1 ec_q);
	c_vco_perp: cover property (VCO_EN && GAP2_LEN == GAP2_PERP_1M);
	c_write_gate_select_500: cover property (WRITE_GATE && PERP_DRIVE && !RATE_1M);
endmodule : fcr_top

/* verification/fcr_drive_model.sv */
// Drive mechanism model: head position and track-zero sensor
`timescale 1ns/10ps
module fcr_drive_model (
	input wire logic clk,
	input wire logic step,
	input wire logic dir,
	output logic trk0_n
);
	int trk = 0;
	logic step_q = 1'b0;
	// Head moves one track per step rise; the carriage stops at track 0
	always @(posedge clk) begin
		step_q <= step;
		if (step && !step_q)
			trk <= dir ? trk + 1 : (trk > 0 ? trk - 1 : 0);
	end
	// Sensor is active low and only reads true at the outer stop
	assign trk0_n = (trk != 0);
endmodule : fcr_drive_model

/* verification/tb.sv */
// Self-checking bench for the configure, seek and perpendicular block
`timescale 1ns/10ps
module tb;
	import fcr_pkg::*;
	localparam logic [7:0] VER = 8'hC3; // Arbitrary value
	logic clk = 0, rst = 1, srst = 0, wr = 0, rd = 0, rwst = 0, r1m = 0;
	logic gs = 0, bt = 0, ra = 0, wa = 0, hl = 0;
	logic [3:0] adr = '0;
	logic [7:0] wd = '0, thv, ptv, rdv;
	logic [1:0] dsel = '0;
	logic trk0_n, stp, dr, busy, pint, isr, byp, pz, pd, vco, wg;
	logic [3:0] thr;
	logic [7:0] ptrk;
	logic [5:0] g2;
	int error_cnt = 0, comparisons = 0, cyl, t, n, tg, e;
	time tl = 0;
	fcr_top #(.STEP_UNIT_CYC(20), .VERSION_BYTE(VER)) dut_u (
		.SYS_CLK(clk), .RESET(rst), .CE(1'b1), .SOFT_RESET(srst),
		.ADDR(adr), .WDATA(wd), .WR_STB(wr), .RD_STB(rd), .RDATA(rdv),
		.TRK0_N(trk0_n), .HEAD_LOADED(hl), .RW_CMD_START(rwst),
		.RATE_1M(r1m), .DRIVE_SEL(dsel), .GAP2_START(gs), .BYTE_TICK(bt),
		.READ_ACTIVE(ra), .WRITE_ACTIVE(wa), .STEP(stp), .DIR(dr),
		.SEEK_BUSY(busy), .POLL_INT(pint), .IMPLIED_SEEK_REQ(isr),
		.FIFO_BYPASS(byp), .FIFO_THRESH(thr), .PRECOMP_TRACK(ptrk),
		.PRECOMP_ZERO(pz), .PERP_DRIVE(pd), .GAP2_LEN(g2), .VCO_EN(vco),
		.WRITE_GATE(wg));
	fcr_drive_model drv_u (.clk(clk), .step(stp), .dir(dr), .trk0_n(trk0_n));
	// Clock and hang guard; a whole run needs well under a millisecond
	initial forever #10 clk = ~clk;
	initial begin
		#1000000;
		error_cnt++;
		stop_test();
	end
	// Count step pulses and keep the latest spacing in cycles
	always @(posedge stp) begin
		n++;
		tg = int'(($time - tl) / 20);
		tl = $time;
	end
	task automatic chk(input logic [7:0] s, input logic [7:0] x,
		input string nm);
		comparisons++;
		if (s !== x) begin
			error_cnt++;
			$display("wrong value %s exp %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] x,
		input string nm);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdv, x, nm);
	endtask : rd_chk
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	// Second command while busy must be ignored, so only one seek runs
	task automatic seek(input logic [7:0] cnt, input logic [7:0] cmd);
		wr_reg(A_RCOUNT, cnt);
		n = 0;
		wr_reg(A_COMMAND, cmd);
		wr_reg(A_COMMAND, cmd);
		#1 chk(dr, cmd[0], "dir");
		for (t = 0; t < 20000 && busy !== 1'b0; t++)
			@(posedge clk);
		chk(busy, 0, "busy");
	endtask : seek
	// Byte ticks on every fourth cycle, so the count is read unambiguously
	task automatic gap(input bit rm, input int x, input string nm);
		@(posedge clk);
		gs <= 1'b1;
		ra <= rm;
		wa <= !rm;
		@(posedge clk);
		gs <= 1'b0;
		for (t = 1; t < 70; t++) begin
			bt <= 1'b1;
			@(posedge clk);
			bt <= 1'b0;
			settle();
			if ((rm ? vco : wg) === 1'b1)
				break;
			@(posedge clk);
		end
		chk(8'(t), 8'(x), nm);
		@(posedge clk);
		ra <= 1'b0;
		wa <= 1'b0;
	endtask : gap
	task automatic stop_test;
		if (error_cnt == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(94489));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		settle();
		chk(pint, 1, "poll");
		chk(byp, 1, "bypass");
		chk(g2, 22, "gap2");
		rd_chk(A_CONFIG, 8'h02, "config");
		rd_chk(A_VERSION, VER, "version");
		rd_chk(A_STATUS, 8'h40, "status");
		rd_chk(A_STATUS, 8'h00, "status");
		rd_chk(4'hF, 8'h00, "unmapped");
		thv = 8'($urandom_range(15));
		ptv = 8'($urandom);
		wr_reg(A_CONFIG, 8'h09);
		wr_reg(A_THRESH, thv);
		wr_reg(A_PRECOMP, ptv);
		rwst <= 1'b1;
		@(posedge clk);
		rwst <= 1'b0;
		#1 chk(isr, 1, "iseek");
		wr_reg(A_PERP, 8'h89);
		dsel <= 2'h1;
		r1m <= 1'b1;
		settle();
		chk(pz, 0, "pzero");
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		settle();
		chk(byp, 0, "bypass");
		chk(thr, thv, "thresh");
		chk(ptrk, ptv, "precomp");
		chk(pint, 1, "poll");
		chk(pz, 1, "pzero");
		chk(pd, 1, "pdrive");
		chk(g2, 41, "gap2");
		wr_reg(A_PERP, 8'h00);
		settle();
		chk(pz, 1, "pzero");
		@(posedge clk);
		dsel <= 2'h0;
		settle();
		chk(pz, 0, "pzero");
		// Modes {write gate, gap}; data rate kept in line by software
		for (int m = 0; m < 4; m++) begin
			wr_reg(A_PERP, 8'(m));
			r1m <= (m == 3);
			settle();
			e = (m == 3) ? 41 : 22;
			chk(g2, 8'(e), "gap2");
			gap(1, e + 2, "vco");
			gap(0, e - (m == 3 ? 38 : (m == 1 ? 19 : 0)), "write_gate_select");
		end
		wr_reg(A_SPECIFY, 8'h0D);
		cyl = 250;
		wr_reg(A_CYL, 8'(cyl));
		seek(8'd10, 8'h03);
		cyl = (cyl + 10) % 256;
		chk(8'(n), 10, "steps");
		chk(8'(tg), 60, "spacing");
		rd_chk(A_CYL, 8'(cyl), "cyl");
		// Soft reset re-armed one poll event, still pending here
		rd_chk(A_STATUS, 8'h60, "status");
		seek(8'd20, 8'h02);
		chk(8'(n), 10, "steps");
		rd_chk(A_CYL, 8'((cyl + 246) % 256), "cyl");
		rd_chk(A_STATUS, 8'h30, "status");
		seek(8'd100, 8'h03);
		chk(8'(drv_u.trk), 100, "track");
		seek(8'd0, 8'h04);
		chk(8'(n), 80, "steps");
		rd_chk(A_STATUS, 8'h30, "status");
		seek(8'd0, 8'h04);
		chk(8'(n), 20, "steps");
		rd_chk(A_CYL, 8'h00, "cyl");
		rd_chk(A_STATUS, 8'h20, "status");
		// Outward seek from track zero is refused without a step
		seek(8'd5, 8'h02);
		chk(8'(n), 0, "steps");
		rd_chk(A_STATUS, 8'h30, "status");
		@(posedge clk);
		hl <= 1'b1;
		dsel <= 2'h1;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		settle();
		chk(pint, 0, "poll");
		chk(pz, 0, "pzero");
		chk(thr, 0, "thresh");
		stop_test();
	end
endmodule : tb
